// ### verilog/srsbc_top.sv
// Overview of operation
// - Mode pin high automatic, low manual
// - Automatic: drive locked or last-locked rate code
// - Unlocked automatic search steps rates, then restarts
// - Unlocked automatic: definition indicator follows tried rate
// - Manual: code pins inputs, lock programmed rate only
// - Codes 000..101 map 143 to 1485 Mb/s
// - Bypass routes input to output unretimed
// - Force input high holds bypass
// - Auto passthrough bypasses only while unlocked
// - Force bypass overrides auto passthrough
// - Unlocked, no bypass: output data invalid
// - Exclude input skips and never locks 177
// - Lock indicator high exactly while locked
// - Lock combines acquisition loops and harmonic check
// - Locked retiming: silence low mutes output
// - Silence ignored while in bypass
// - Frequency acquisition locks within one percent
// - Phase loop drops lock beyond two percent
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
module srsbc_top
   import srsbc_pkg::*;
#(
   parameter int DWELL_W = 16
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rate_mode_select,
   input wire logic [2:0] rate_code_in,
   output logic [2:0] rate_code_out,
   output logic rate_code_oe,
   input wire logic force_passthrough,
   input wire logic auto_passthrough_enable,
   input wire logic output_silence_n,
   input wire logic transport_rate_exclude,
   input wire logic freq_within_1pct,
   input wire logic freq_within_2pct,
   input wire logic phase_acquisition_ok,
   input wire logic harmonic_detect,
   output logic lock_indicator,
   output logic definition_indicator,
   output logic [2:0] vco_rate_sel,
   output logic [1:0] serial_out_path
);
   // ********************************
   // Elaboration check
   // ********************************
   if (DWELL_W > 31 || SRSBC_DWELL_CYC >= (1 << DWELL_W)) begin : g_chk
      $error("DWELL_W too narrow for dwell count");
   end

   // ********************************
   // Pin synchronisers
   // ********************************
   localparam int NS = 12;
   logic [NS-1:0] pin_raw; // Asynchronous pin levels
   logic [NS-1:0] sync1; // First stage, read only by sync2
   logic [NS-1:0] sync2; // Safe to use
   assign pin_raw = {rate_mode_select, rate_code_in, force_passthrough,
      auto_passthrough_enable, output_silence_n, transport_rate_exclude,
      freq_within_1pct, freq_within_2pct, phase_acquisition_ok, harmonic_detect};

   // Two stages per pin; pins toggle freely against clk_sys
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
      end
   end

   logic mode_s; // High: automatic search
   logic [2:0] man_code_s; // Programmed rate in manual mode
   logic force_s, auto_s, silence_n_s, excl_s;
   logic f1_s, f2_s, phase_s, harm_s;
   assign {mode_s, man_code_s, force_s, auto_s, silence_n_s, excl_s,
      f1_s, f2_s, phase_s, harm_s} = sync2;

   // ********************************
   // Rate helpers
   // ********************************
   // Code is a supported rate and not excluded
   function automatic logic rate_ok(input logic [2:0] c, input logic ex);
      rate_ok = (c <= SRSBC_RATE_LAST) && !(ex && c == SRSBC_RATE_177);
   endfunction

   // Next candidate: ascending, skip excluded, wrap
   function automatic logic [2:0] rate_step(input logic [2:0] c, input logic ex);
      logic [2:0] n;
      n = (c >= SRSBC_RATE_LAST) ? SRSBC_RATE_FIRST : 3'(c + 3'h1);
      if (ex && n == SRSBC_RATE_177) begin
         n = SRSBC_RATE_270;
      end
      rate_step = n;
   endfunction

   // ********************************
   // Acquisition control
   // ********************************
   srsbc_state_t state, next_state; // Loop in charge
   logic [2:0] cand, next_cand; // Rate being tried by the search
   logic [2:0] locked_rate, next_locked_rate; // Rate last locked to
   logic [DWELL_W-1:0] dwell, next_dwell; // Countdown per candidate
   logic [DWELL_W-1:0] dwell_load; // Software dwell setting
   logic [2:0] target; // Rate the loop aims at now

   // Automatic mode follows the search, manual the pins
   assign target = mode_s ? cand : man_code_s;

   // Next state of the loop control
   always_comb begin
      next_state = state;
      next_cand = cand;
      next_locked_rate = locked_rate;
      next_dwell = dwell;
      unique case (state)
         SRSBC_FREQ_ACQ: begin
            if (f1_s && !harm_s && rate_ok(target, excl_s)) begin
               // Within one percent, no harmonic: hand to phase loop
               next_state = SRSBC_PHASE_ACQ;
               next_locked_rate = target;
               next_dwell = dwell_load;
            end else if (!mode_s) begin
               // Manual: no search, wait on programmed rate
               next_dwell = dwell_load;
            end else if (dwell == '0 || !rate_ok(cand, excl_s)) begin
               next_cand = rate_step(cand, excl_s);
               next_dwell = dwell_load;
            end else begin
               next_dwell = dwell - 1'b1;
            end
         end
         SRSBC_PHASE_ACQ: begin
            // Beyond two percent, harmonic, or target moved: reacquire
            if (!f2_s || harm_s || !rate_ok(target, excl_s)
                  || target != locked_rate) begin
               next_state = SRSBC_FREQ_ACQ;
               next_dwell = dwell_load;
            end
         end
      endcase
   end

   // Register loop control
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= SRSBC_FREQ_ACQ;
         cand <= SRSBC_RATE_FIRST;
         locked_rate <= SRSBC_RATE_FIRST;
         dwell <= DWELL_W'(SRSBC_DWELL_CYC);
      end else begin
         state <= next_state;
         cand <= next_cand;
         locked_rate <= next_locked_rate;
         dwell <= next_dwell;
      end
   end

   // ********************************
   // Indicators and output path
   // ********************************
   logic next_lock; // Lock as it will show next cycle
   logic [2:0] next_code_out, next_vco; // Code pins and divider select
   logic next_hd;
   srsbc_path_t next_path;

   // Compute pin-side outputs from the next loop state
   always_comb begin
      // Both loops and the harmonic monitor must agree
      next_lock = (next_state == SRSBC_PHASE_ACQ) && phase_s && !harm_s;
      // Last locked rate stays on the pins while unlocked
      next_code_out = next_locked_rate;
      next_vco = next_lock ? next_locked_rate : (mode_s ? next_cand : man_code_s);
      // Unlocked search makes this toggle with the candidate
      next_hd = (next_vco == SRSBC_RATE_1485);
      if (force_s) begin
         next_path = SRSBC_PATH_BYPASS;
      end else if (auto_s && !next_lock) begin
         next_path = SRSBC_PATH_BYPASS;
      end else if (next_lock && !silence_n_s) begin
         // Analog side holds a steady level, no transitions
         next_path = SRSBC_PATH_MUTE;
      end else begin
         // Unlocked here carries no valid data
         next_path = SRSBC_PATH_RETIME;
      end
   end

   // Every output comes straight from a flop
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         lock_indicator <= 1'b0;
         rate_code_out <= SRSBC_RATE_FIRST;
         rate_code_oe <= 1'b0;
         definition_indicator <= 1'b0;
         vco_rate_sel <= SRSBC_RATE_FIRST;
         serial_out_path <= SRSBC_PATH_RETIME;
      end else begin
         lock_indicator <= next_lock;
         rate_code_out <= next_code_out;
         rate_code_oe <= mode_s;
         definition_indicator <= next_hd;
         vco_rate_sel <= next_vco;
         serial_out_path <= next_path;
      end
   end

   // ********************************
   // AHB-Lite slave
   // ********************************
   logic wr_pend, next_wr_pend; // Write data phase due
   logic [7:0] wr_addr, next_wr_addr;
   logic [DWELL_W-1:0] next_dwell_load;
   logic [31:0] next_rdata;
   logic [31:0] status; // Live state view
   logic take; // Address phase accepted

   assign take = hsel && hready && htrans[1];
   assign status = 32'({serial_out_path, 1'b0, cand, 1'b0, locked_rate,
      state == SRSBC_PHASE_ACQ, mode_s, definition_indicator, lock_indicator});

   // Decode; read data is ready in the data phase, no waits
   always_comb begin
      next_wr_pend = take && hwrite;
      next_wr_addr = take ? haddr[7:0] : wr_addr;
      next_dwell_load = dwell_load;
      next_rdata = hrdata;
      if (wr_pend && wr_addr == SRSBC_ADDR_CTRL) begin
         next_dwell_load = hwdata[DWELL_W-1:0];
      end
      if (take && !hwrite) begin
         if (haddr[7:0] == SRSBC_ADDR_CTRL && haddr[31:8] == '0) begin
            next_rdata = 32'(dwell_load);
         end else if (haddr[7:0] == SRSBC_ADDR_STATUS && haddr[31:8] == '0) begin
            next_rdata = status;
         end else begin
            // Unmapped reads return zero, still OKAY
            next_rdata = '0;
         end
      end
   end

   // Register the bus side; never a wait state, always OKAY
   always_ff @(posedge clk_sys) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (sys_rst) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         dwell_load <= DWELL_W'(SRSBC_DWELL_CYC);
         hrdata <= '0;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         dwell_load <= next_dwell_load;
         hrdata <= next_rdata;
      end
   end

   // ********************************
   // Assertions
   // ********************************
   property p_oe_mode;
      @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> (rate_code_oe == $past(mode_s));
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("Code pin drive wrong");
   property p_lock_phase;
      @(posedge clk_sys) disable iff (sys_rst)
      lock_indicator |-> (state == SRSBC_PHASE_ACQ);
   endproperty
   a_lock_phase: assert property (p_lock_phase) else $error("Lock outside phase loop");
   property p_no177;
      @(posedge clk_sys) disable iff (sys_rst)
      $past(excl_s) |-> !(lock_indicator && locked_rate == SRSBC_RATE_177);
   endproperty
   a_no177: assert property (p_no177) else $error("Locked to excluded rate");
   property p_force;
      @(posedge clk_sys) disable iff (sys_rst)
      $past(force_s) |-> (serial_out_path == SRSBC_PATH_BYPASS);
   endproperty
   a_force: assert property (p_force) else $error("Force bypass lost");
   property p_autobyp;
      @(posedge clk_sys) disable iff (sys_rst)
      $past(auto_s) |-> (lock_indicator || serial_out_path == SRSBC_PATH_BYPASS);
   endproperty
   a_autobyp: assert property (p_autobyp) else $error("Auto bypass missing");
   property p_mute;
      @(posedge clk_sys) disable iff (sys_rst)
      ($past(!silence_n_s) && $past(!force_s) && $past(!auto_s) && lock_indicator)
         |-> (serial_out_path == SRSBC_PATH_MUTE);
   endproperty
   a_mute: assert property (p_mute) else $error("Mute not applied");
   // Auto passthrough only bypasses while unlocked, so mute may follow a lock
   property p_mute_byp;
      @(posedge clk_sys) disable iff (sys_rst)
      (serial_out_path == SRSBC_PATH_MUTE)
         |-> (!$past(force_s) && !($past(auto_s) && !lock_indicator));
   endproperty
   a_mute_byp: assert property (p_mute_byp) else $error("Mute during bypass");
   property p_step;
      @(posedge clk_sys) disable iff (sys_rst)
      ($past(mode_s) && $changed(cand)) |-> (cand == rate_step($past(cand), $past(excl_s)));
   endproperty
   a_step: assert property (p_step) else $error("Bad search step");
   property p_hd_search;
      @(posedge clk_sys) disable iff (sys_rst)
      ($past(mode_s) && !lock_indicator && $past(state) == SRSBC_FREQ_ACQ)
         |-> (definition_indicator == (cand == SRSBC_RATE_1485));
   endproperty
   a_hd_search: assert property (p_hd_search) else $error("Indicator not tracking");
   property p_freq_lock;
      @(posedge clk_sys) disable iff (sys_rst)
      (state == SRSBC_PHASE_ACQ && $past(state) == SRSBC_FREQ_ACQ)
         |-> ($past(f1_s) && !$past(harm_s));
   endproperty
   a_freq_lock: assert property (p_freq_lock) else $error("Lock without 1pct match");
   property p_phase_loss;
      @(posedge clk_sys) disable iff (sys_rst)
      (state == SRSBC_PHASE_ACQ && !f2_s) |=> (state == SRSBC_FREQ_ACQ) && !lock_indicator;
   endproperty
   a_phase_loss: assert property (p_phase_loss) else $error("2pct loss ignored");
   property p_manual;
      @(posedge clk_sys) disable iff (sys_rst)
      ($past(!mode_s) && state == SRSBC_PHASE_ACQ) |-> (locked_rate == $past(man_code_s));
   endproperty
   a_manual: assert property (p_manual) else $error("Manual lock off rate");
endmodule

// ### verilog/srsbc_pkg.sv
package srsbc_pkg;
   // ********************************
   // Rate codes on the rate code pins
   // ********************************
   localparam logic [2:0] SRSBC_RATE_143 = 3'h0;
   localparam logic [2:0] SRSBC_RATE_177 = 3'h1;
   localparam logic [2:0] SRSBC_RATE_270 = 3'h2;
   localparam logic [2:0] SRSBC_RATE_360 = 3'h3;
   localparam logic [2:0] SRSBC_RATE_540 = 3'h4;
   localparam logic [2:0] SRSBC_RATE_1485 = 3'h5;
   localparam logic [2:0] SRSBC_RATE_FIRST = SRSBC_RATE_143;
   localparam logic [2:0] SRSBC_RATE_LAST = SRSBC_RATE_1485;

   // ********************************
   // Timing
   // ********************************
   localparam int SRSBC_CLK_HZ = 40_000_000;
   // Time spent on one candidate rate before stepping on
   localparam int SRSBC_DWELL_US = 100;
   localparam int SRSBC_DWELL_CYC = (SRSBC_CLK_HZ / 1_000_000) * SRSBC_DWELL_US;

   // ********************************
   // Register map, byte addresses
   // ********************************
   localparam logic [7:0] SRSBC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] SRSBC_ADDR_STATUS = 8'h04;
   // Status fields
   localparam int SRSBC_ST_LOCK_BIT = 0;
   localparam int SRSBC_ST_HD_BIT = 1;
   localparam int SRSBC_ST_AUTO_BIT = 2;
   localparam int SRSBC_ST_PHASE_BIT = 3;
   localparam int SRSBC_ST_RATE_LSB = 4;
   localparam int SRSBC_ST_CAND_LSB = 8;
   localparam int SRSBC_ST_PATH_LSB = 12;

   // ********************************
   // Types
   // ********************************
   typedef enum logic {
      SRSBC_FREQ_ACQ = 1'b0,
      SRSBC_PHASE_ACQ = 1'b1
   } srsbc_state_t;

   typedef enum logic [1:0] {
      SRSBC_PATH_RETIME = 2'b00,
      SRSBC_PATH_BYPASS = 2'b01,
      SRSBC_PATH_MUTE = 2'b10
   } srsbc_path_t;
endpackage

// ### verif/srsbc_board.sv
// ****************************************
// Board controller model on the pin side
// ****************************************
module srsbc_board (
   input wire logic clk_sys,
   output logic rate_mode_select = 1'h1,
   output logic [2:0] board_code = 3'h0,
   output logic board_code_en,
   output logic force_passthrough = 1'h0,
   output logic auto_passthrough_enable = 1'h0,
   output logic output_silence_n = 1'h1,
   output logic transport_rate_exclude = 1'h0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] held_code = 3'h0; // Code programmed for manual mode
   // Board drives the code pins only in manual mode
   assign board_code_en = !rate_mode_select;
   // Released pins float: show a pattern that changes every cycle, not a stale code
   always @(posedge clk_sys) begin
      board_code <= board_code_en ? held_code : ~board_code;
   end
   // Mode pin: high automatic, low manual
   task set_mode(input logic auto_mode);
      @(posedge clk_sys);
      rate_mode_select <= auto_mode;
   endtask
   // Programmed rate code, 3-bit, bit 2 most significant
   task set_code(input logic [2:0] c);
      @(posedge clk_sys);
      held_code <= c;
   endtask
   // Bypass, silence and exclusion pins together
   task set_pins(input logic f, input logic a, input logic s, input logic x);
      @(posedge clk_sys);
      force_passthrough <= f;
      auto_passthrough_enable <= a;
      output_silence_n <= s;
      transport_rate_exclude <= x;
   endtask
endmodule

// ### verif/srsbc_top_bench.sv
// ****************************************
// Bench for the rate select and bypass block
// ****************************************
module srsbc_top_bench import srsbc_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] hsize = 3'h2; // Word transfers only
   logic hreadyout, hresp, rate_code_oe, lock, defn, code_en;
   logic [31:0] hrdata, rd;
   logic [2:0] rate_code_out, board_code, code_wire, vco;
   logic [1:0] path;
   logic mode, force_p, auto_p, silence_n, excl;
   logic f1 = 1'h0, f2 = 1'h0, ph = 1'h0, hm = 1'h0; // Analog loop status
   int miscompares = 0;
   int comparisons = 0;
   // Candidate order seen by the search; exclusion turns on after entry 5
   logic [2:0] seq [11] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
   // Code pins wire: device wins while it drives
   assign code_wire = rate_code_oe ? rate_code_out : board_code;
   always #12.5 clk_sys = ~clk_sys;
   srsbc_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rate_mode_select(mode),
      .rate_code_in(code_wire), .rate_code_out(rate_code_out), .rate_code_oe(rate_code_oe),
      .force_passthrough(force_p), .auto_passthrough_enable(auto_p),
      .output_silence_n(silence_n), .transport_rate_exclude(excl), .freq_within_1pct(f1),
      .freq_within_2pct(f2), .phase_acquisition_ok(ph), .harmonic_detect(hm),
      .lock_indicator(lock), .definition_indicator(defn), .vco_rate_sel(vco),
      .serial_out_path(path));
   srsbc_board i_board (.clk_sys(clk_sys), .rate_mode_select(mode), .board_code(board_code),
      .board_code_en(code_en), .force_passthrough(force_p), .auto_passthrough_enable(auto_p),
      .output_silence_n(silence_n), .transport_rate_exclude(excl));
   // ****************************************
   // Compare, bus and stimulus tasks
   // ****************************************
   task chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task chk3(input logic [2:0] got, input logic [2:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: code %h expected %h", $time, got, exp);
      end
   endtask
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // One single AHB transfer; read data lands in rd
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk_sys);
      while (hreadyout !== 1'h1) @(posedge clk_sys);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'h1) @(posedge clk_sys);
      rd = hrdata;
   endtask
   task loops(input logic a, input logic b, input logic c, input logic d);
      @(posedge clk_sys);
      f1 <= a;
      f2 <= b;
      ph <= c;
      hm <= d;
   endtask
   // Wait for the next candidate; dwell is long enough for the indicator check
   task step(input logic [2:0] v);
      logic [2:0] prev;
      prev = vco;
      while (vco === prev) @(posedge clk_sys);
      chk3(vco, v);
      cyc(3);
      chk1(defn, v === 3'h5);
   endtask
   task final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      cyc(8);
      sys_rst <= 1'h0;
      chk1(hreadyout, 1'h1);
      chk1(hresp, 1'h0);
      chk1(lock, 1'h0);
      ahb(1'h0, SRSBC_ADDR_CTRL, 32'h0);
      chk32(rd, 32'h0000_0FA0);
      ahb(1'h0, 8'h10, 32'h0);
      chk32(rd, 32'h0); // Unmapped reads zero
      ahb(1'h1, SRSBC_ADDR_CTRL, 32'h14);
      ahb(1'h0, SRSBC_ADDR_CTRL, 32'h0);
      chk32(rd, 32'h0000_0014); // Dwell setting reads back
      for (int i = 0; i < 11; i++) begin
         if (i == 6) i_board.set_pins(1'h0, 1'h0, 1'h1, 1'h1);
         step(seq[i]);
      end
      i_board.set_pins(1'h0, 1'h0, 1'h1, 1'h0);
      // Lock on 270 while searching
      while (vco !== 3'h2) @(posedge clk_sys);
      loops(1'h1, 1'h1, 1'h1, 1'h0);
      cyc(6);
      chk1(lock, 1'h1);
      chk3(rate_code_out, 3'h2);
      chk1(rate_code_oe, 1'h1);
      chk1(code_en, 1'h0);
      ahb(1'h0, SRSBC_ADDR_STATUS, 32'h0);
      chk32(rd, 32'h0000_022D);
      i_board.set_pins(1'h0, 1'h0, 1'h0, 1'h0);
      cyc(6);
      chk3({1'h0, path}, 3'h2);
      i_board.set_pins(1'h0, 1'h1, 1'h0, 1'h0);
      cyc(6);
      chk3({1'h0, path}, 3'h2);
      i_board.set_pins(1'h1, 1'h1, 1'h0, 1'h0);
      cyc(6);
      chk3({1'h0, path}, 3'h1);
      ahb(1'h0, SRSBC_ADDR_STATUS, 32'h0);
      chk32(rd, 32'h0000_122D);
      i_board.set_pins(1'h0, 1'h1, 1'h1, 1'h0);
      cyc(6);
      chk3({1'h0, path}, 3'h0);
      loops(1'h1, 1'h1, 1'h1, 1'h1);
      cyc(6);
      chk1(lock, 1'h0);
      chk3({1'h0, path}, 3'h1);
      chk3(rate_code_out, 3'h2);
      loops(1'h0, 1'h1, 1'h1, 1'h0);
      cyc(6);
      chk1(lock, 1'h0);
      loops(1'h1, 1'h1, 1'h1, 1'h0);
      cyc(4);
      loops(1'h0, 1'h1, 1'h1, 1'h0);
      cyc(6);
      chk1(lock, 1'h1);
      loops(1'h0, 1'h0, 1'h1, 1'h0);
      cyc(6);
      chk1(lock, 1'h0);
      i_board.set_pins(1'h0, 1'h0, 1'h1, 1'h0);
      cyc(6);
      chk3({1'h0, path}, 3'h0);
      // Manual mode over every rate code and unsupported code 6
      loops(1'h0, 1'h0, 1'h0, 1'h0);
      i_board.set_mode(1'h0);
      cyc(6);
      chk1(rate_code_oe, 1'h0);
      chk1(code_en, 1'h1);
      for (int c = 0; c < 7; c++) begin
         i_board.set_code(3'(c));
         cyc(30);
         if (c < 6) chk3(vco, 3'(c));
         loops(1'h1, 1'h1, 1'h1, 1'h0);
         cyc(6);
         chk1(lock, c < 6);
         if (c < 6) chk3(rate_code_out, 3'(c));
         if (c < 6) chk1(defn, c == 5);
         loops(1'h0, 1'h0, 1'h0, 1'h0);
         cyc(6);
      end
      // Excluded rate is refused in manual mode too
      i_board.set_pins(1'h0, 1'h0, 1'h1, 1'h1);
      i_board.set_code(3'h1);
      cyc(6);
      loops(1'h1, 1'h1, 1'h1, 1'h0);
      cyc(30);
      chk1(lock, 1'h0);
      i_board.set_pins(1'h0, 1'h0, 1'h1, 1'h0);
      cyc(8);
      chk1(lock, 1'h1);
      final_report;
   end
   // Watchdog: whole run needs well under this many cycles
   initial begin
      cyc(20000);
      miscompares++;
      final_report;
   end
endmodule
